// >>> design/dpc_arb_if.sv
`default_nettype none

interface dpc_arb_if;
	logic [dpc_pkg::NUM_CH-1:0] req;
	logic [dpc_pkg::NUM_CH-1:0] no_rr;
	logic [dpc_pkg::PRIO_W-1:0] prio [dpc_pkg::NUM_CH];
	logic                       fair_en;
	logic                       take;
	logic                       gnt_valid;
	logic [dpc_pkg::CH_W-1:0]   gnt_ch;

	modport eng (output req, no_rr, prio, fair_en, take,
		input gnt_valid, gnt_ch);
	modport arb (input req, no_rr, prio, fair_en, take,
		output gnt_valid, gnt_ch);
endinterface

`default_nettype wire

// >>> design/dpc_arbiter.sv
`default_nettype none

module dpc_arbiter
(
	// Clock, reset and enable.
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic ce,
	// Requests from the engine.
	dpc_arb_if.arb    ab
);

	logic [dpc_pkg::CH_W-1:0]   last_r [dpc_pkg::NUM_LVL];
	logic [dpc_pkg::SLOT_W-1:0] slot_r;
	logic [dpc_pkg::NUM_LVL-1:0] lvl_any;
	logic [dpc_pkg::PRIO_W-1:0] lvl;
	logic [dpc_pkg::PRIO_W-1:0] fav;
	logic                       found;
	int                         idx;

	// ****************************************************************
	// Fairness slot decode
	// ****************************************************************
	// Lowest clear bit i of the slot favours level 2+i, so level 2 owns
	// every second slot, level 7 one in 64; an all-ones slot favours none.
	function automatic logic [2:0] fav_lvl(input logic [5:0] s);
		logic [2:0] l;
		l = 3'h0;
		for (int i = 5; i >= 0; i--)
			if (!s[i])
				l = dpc_pkg::FAIR_LVL_MIN + 3'(i);
		return l;
	endfunction

	always_comb
	begin
		lvl_any = '0;
		for (int c = 0; c < dpc_pkg::NUM_CH; c++)
			if (ab.req[c])
				lvl_any[ab.prio[c]] = 1'b1;
		lvl = 3'h7;
		for (int l = dpc_pkg::NUM_LVL - 1; l >= 0; l--)
			if (lvl_any[l])
				lvl = 3'(l);
		fav = fav_lvl(slot_r);
		if (ab.fair_en && !lvl_any[0] && !lvl_any[1]
			&& fav != 3'h0 && lvl_any[fav])
			lvl = fav;
		found = 1'b0;
		ab.gnt_ch = '0;
		for (int c = 0; c < dpc_pkg::NUM_CH; c++)
			if (!found && ab.req[c] && ab.no_rr[c] && ab.prio[c] == lvl)
			begin
				found = 1'b1;
				ab.gnt_ch = 5'(c);
			end
		for (int k = 1; k <= dpc_pkg::NUM_CH; k++)
		begin
			idx = (int'(last_r[lvl]) + k) % dpc_pkg::NUM_CH;
			if (!found && ab.req[idx] && ab.prio[idx] == lvl)
			begin
				found = 1'b1;
				ab.gnt_ch = 5'(idx);
			end
		end
		ab.gnt_valid = |ab.req;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			slot_r <= '0;
			for (int l = 0; l < dpc_pkg::NUM_LVL; l++)
				last_r[l] <= '0;
		end
		else if (ce && ab.take)
		begin
			last_r[lvl] <= ab.gnt_ch;
			if (ab.fair_en)
				slot_r <= slot_r + 6'h1;
		end
	end

endmodule

`default_nettype wire

// >>> design/dpc_pkg.sv
`default_nettype none

package dpc_pkg;

	// ****************************************************************
	// Sizes
	// ****************************************************************
	localparam int NUM_CH    = 24;
	localparam int NUM_DESC  = 128;
	localparam int NUM_LVL   = 8;
	localparam int CH_W      = 5;
	localparam int DESC_W    = 7;
	localparam int PRIO_W    = 3;
	localparam int LEN_W     = 16;
	localparam int BADDR_W   = 16;
	localparam int RADDR_W   = 12;
	localparam int CFG_W     = 19;
	localparam int CTL_W     = 21;
	localparam int SLOT_W    = 6;

	// ****************************************************************
	// Register word offsets
	// ****************************************************************
	localparam logic [11:0] REG_CTRL      = 12'h000;
	localparam logic [11:0] REG_STAT      = 12'h001;
	localparam logic [11:0] REG_TRIG      = 12'h002;
	localparam logic [11:0] REG_CANCEL    = 12'h003;
	localparam logic [11:0] REG_CFG_BASE  = 12'h040;
	localparam logic [11:0] REG_CHST_BASE = 12'h060;
	localparam logic [11:0] REG_DESC_BASE = 12'h200;
	localparam logic [11:0] DESC_SPAN     = 12'h200;

	// ****************************************************************
	// Field positions and reset values
	// ****************************************************************
	localparam int CTRL_EN_BIT    = 0;
	localparam int CTRL_FAIR_BIT  = 1;
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam int CFG_PRIO_LSB   = 0;
	localparam int CFG_NORR_BIT   = 3;
	localparam int CFG_EN_BIT     = 4;
	localparam int CFG_STALL_BIT  = 5;
	localparam int CFG_FIRST_LSB  = 6;
	localparam int CFG_CHEN_BIT   = 13;
	localparam int CFG_CHTGT_LSB  = 14;
	localparam int CTL_UNB_BIT    = 16;
	localparam int CTL_SINC_BIT   = 17;
	localparam int CTL_DINC_BIT   = 18;
	localparam int CTL_EVT_BIT    = 19;
	localparam int CTL_LAST_BIT   = 20;
	localparam logic [1:0] DW_SRC  = 2'h0;
	localparam logic [1:0] DW_DST  = 2'h1;
	localparam logic [1:0] DW_CTL  = 2'h2;
	localparam logic [1:0] DW_NEXT = 2'h3;

	// ****************************************************************
	// Counts
	// ****************************************************************
	localparam logic [3:0] CPU_WAIT_MAX = 4'hF;
	localparam logic [2:0] FAIR_LVL_MIN = 3'h2;

	typedef enum {ST_IDLE, ST_READ, ST_WRITE} dpc_state_e;

endpackage

`default_nettype wire

// >>> design/dpc_top.sv
// The strobed register port and the address map were decided locally.
`default_nettype none

module dpc_top
(
	// Clock, reset and clock enable.
	input  wire logic                         clk,
	input  wire logic                         sys_rst,
	input  wire logic                         ce,
	// Register port.
	input  wire logic [dpc_pkg::RADDR_W-1:0]  reg_addr,
	input  wire logic [31:0]                  reg_wdata,
	input  wire logic                         reg_wr,
	input  wire logic                         reg_rd,
	output logic      [31:0]                  reg_rdata,
	// Trigger pins.
	input  wire logic [dpc_pkg::NUM_CH-1:0]   trig_in,
	// System bus master.
	input  wire logic                         cpu_req,
	output logic                              bus_req,
	output logic                              bus_we,
	output logic      [dpc_pkg::BADDR_W-1:0]  bus_addr,
	output logic      [7:0]                   bus_wdata,
	input  wire logic [7:0]                   bus_rdata,
	input  wire logic                         bus_ack,
	// Channel events.
	output logic      [dpc_pkg::NUM_CH-1:0]   ch_evt_done,
	output logic      [dpc_pkg::NUM_CH-1:0]   ch_evt_end
);

	localparam int NC = dpc_pkg::NUM_CH;
	localparam int ND = dpc_pkg::NUM_DESC;

	// ****************************************************************
	// Storage
	// ****************************************************************
	logic [1:0]                  ctrl_r;
	logic [dpc_pkg::CFG_W-1:0]   cfg_r [NC];
	logic [15:0]                 dsrc_r [ND];
	logic [15:0]                 ddst_r [ND];
	logic [dpc_pkg::CTL_W-1:0]   dctl_r [ND];
	logic [dpc_pkg::DESC_W-1:0]  dnext_r [ND];
	logic [NC-1:0]               act_r;
	logic [dpc_pkg::DESC_W-1:0]  cdesc_r [NC];
	logic [dpc_pkg::LEN_W-1:0]   ccnt_r [NC];
	logic [15:0]                 csrc_r [NC];
	logic [15:0]                 cdst_r [NC];

	// ****************************************************************
	// Engine and glue
	// ****************************************************************
	dpc_pkg::dpc_state_e         state_r;
	logic [dpc_pkg::CH_W-1:0]    eng_ch_r;
	logic [3:0]                  wait_r;
	logic                        bus_req_r;
	logic                        bus_we_r;
	logic [15:0]                 bus_addr_r;
	logic [7:0]                  bus_wdata_r;
	logic [31:0]                 rdata_r;
	logic [NC-1:0]               evt_done_r;
	logic [NC-1:0]               evt_end_r;
	logic                        chain_go_r;
	logic [dpc_pkg::CH_W-1:0]    chain_tgt_r;
	logic [NC-1:0]               trig_s1_r;
	logic [NC-1:0]               trig_s2_r;
	logic [NC-1:0]               trig_s3_r;
	logic [NC-1:0]               start;
	logic [NC-1:0]               cancel;
	logic [NC-1:0]               adv;
	logic [NC-1:0]               ld;
	logic [dpc_pkg::DESC_W-1:0]  li [NC];
	logic [dpc_pkg::CTL_W-1:0]   eng_ctl;
	logic                        done_byte;
	logic                        eng_end;
	logic [6:0]                  dsel;
	logic [1:0]                  dfld;

	dpc_arb_if ab ();

	dpc_arbiter u_arb
	(
		.clk     (clk),
		.sys_rst (sys_rst),
		.ce      (ce),
		.ab      (ab)
	);

	function automatic logic hit(input logic [11:0] a,
		input logic [11:0] base, input logic [11:0] n);
		return (a >= base) && (a < base + n);
	endfunction

	assign reg_rdata   = rdata_r;
	assign bus_req     = bus_req_r;
	assign bus_we      = bus_we_r;
	assign bus_addr    = bus_addr_r;
	assign bus_wdata   = bus_wdata_r;
	assign ch_evt_done = evt_done_r;
	assign ch_evt_end  = evt_end_r;

	assign dsel = 7'((reg_addr - dpc_pkg::REG_DESC_BASE) >> 2);
	assign dfld = reg_addr[1:0];

	// ****************************************************************
	// Trigger synchroniser
	// ****************************************************************
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			trig_s1_r <= '0;
			trig_s2_r <= '0;
			trig_s3_r <= '0;
		end
		else if (ce)
		begin
			trig_s1_r <= trig_in;
			trig_s2_r <= trig_s1_r;
			trig_s3_r <= trig_s2_r;
		end
	end

	// ****************************************************************
	// Channel control decode
	// ****************************************************************
	assign eng_ctl = dctl_r[cdesc_r[eng_ch_r]];
	assign done_byte = (state_r == dpc_pkg::ST_WRITE) && bus_req_r
		&& bus_ack;
	assign eng_end = (ccnt_r[eng_ch_r] == '0)
		&& !eng_ctl[dpc_pkg::CTL_UNB_BIT];

	always_comb
	begin
		for (int c = 0; c < NC; c++)
		begin
			start[c] = cfg_r[c][dpc_pkg::CFG_EN_BIT]
				&& ((trig_s2_r[c] && !trig_s3_r[c])
				|| (reg_wr && reg_addr == dpc_pkg::REG_TRIG
				&& reg_wdata[4:0] == 5'(c))
				|| (chain_go_r && chain_tgt_r == 5'(c)));
			cancel[c] = reg_wr && reg_addr == dpc_pkg::REG_CANCEL
				&& reg_wdata[4:0] == 5'(c);
			adv[c] = done_byte && eng_ch_r == 5'(c) && act_r[c];
			ld[c] = (adv[c] && eng_end
				&& !eng_ctl[dpc_pkg::CTL_LAST_BIT])
				|| (start[c] && !act_r[c]);
			li[c] = adv[c] ? dnext_r[cdesc_r[c]]
				: cfg_r[c][dpc_pkg::CFG_FIRST_LSB +: 7];
			ab.req[c] = act_r[c] && cfg_r[c][dpc_pkg::CFG_EN_BIT]
				&& !cfg_r[c][dpc_pkg::CFG_STALL_BIT];
			ab.no_rr[c] = cfg_r[c][dpc_pkg::CFG_NORR_BIT];
			ab.prio[c] = cfg_r[c][dpc_pkg::CFG_PRIO_LSB +: 3];
		end
		ab.fair_en = ctrl_r[dpc_pkg::CTRL_FAIR_BIT];
	end
	assign ab.take = (state_r == dpc_pkg::ST_IDLE)
		&& ctrl_r[dpc_pkg::CTRL_EN_BIT] && ab.gnt_valid;

	// ****************************************************************
	// Register writes
	// ****************************************************************
	// The pool takes writes at any time; a channel copies source, destination and count when it
	// loads a descriptor, so edits to those apply from the next load; its control and next words are read live.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			ctrl_r <= dpc_pkg::CTRL_RST;
			for (int c = 0; c < NC; c++)
				cfg_r[c] <= '0;
			for (int d = 0; d < ND; d++)
			begin
				dsrc_r[d] <= '0;
				ddst_r[d] <= '0;
				dctl_r[d] <= '0;
				dnext_r[d] <= '0;
			end
		end
		else if (ce && reg_wr)
		begin
			if (reg_addr == dpc_pkg::REG_CTRL)
				ctrl_r <= reg_wdata[1:0];
			if (hit(reg_addr, dpc_pkg::REG_CFG_BASE, 12'(NC)))
				cfg_r[5'(reg_addr - dpc_pkg::REG_CFG_BASE)]
					<= reg_wdata[dpc_pkg::CFG_W-1:0];
			if (hit(reg_addr, dpc_pkg::REG_DESC_BASE, dpc_pkg::DESC_SPAN))
			begin
				unique case (dfld)
					dpc_pkg::DW_SRC:  dsrc_r[dsel] <= reg_wdata[15:0];
					dpc_pkg::DW_DST:  ddst_r[dsel] <= reg_wdata[15:0];
					dpc_pkg::DW_CTL:
						dctl_r[dsel] <= reg_wdata[dpc_pkg::CTL_W-1:0];
					dpc_pkg::DW_NEXT: dnext_r[dsel] <= reg_wdata[6:0];
				endcase
			end
		end
	end

	// ****************************************************************
	// Register reads
	// ****************************************************************
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			rdata_r <= '0;
		else if (ce)
		begin
			rdata_r <= '0;
			if (reg_rd)
			begin
				if (reg_addr == dpc_pkg::REG_CTRL)
					rdata_r <= 32'(ctrl_r);
				if (reg_addr == dpc_pkg::REG_STAT)
					rdata_r <= {26'h0,
						state_r != dpc_pkg::ST_IDLE, eng_ch_r};
				if (hit(reg_addr, dpc_pkg::REG_CFG_BASE, 12'(NC)))
					rdata_r <= 32'(cfg_r[5'(reg_addr
						- dpc_pkg::REG_CFG_BASE)]);
				if (hit(reg_addr, dpc_pkg::REG_CHST_BASE, 12'(NC)))
				begin
					rdata_r <= {8'h0,
						act_r[5'(reg_addr - dpc_pkg::REG_CHST_BASE)],
						cdesc_r[5'(reg_addr - dpc_pkg::REG_CHST_BASE)],
						ccnt_r[5'(reg_addr - dpc_pkg::REG_CHST_BASE)]};
				end
				if (hit(reg_addr, dpc_pkg::REG_DESC_BASE,
					dpc_pkg::DESC_SPAN))
				begin
					unique case (dfld)
						dpc_pkg::DW_SRC:  rdata_r <= 32'(dsrc_r[dsel]);
						dpc_pkg::DW_DST:  rdata_r <= 32'(ddst_r[dsel]);
						dpc_pkg::DW_CTL:  rdata_r <= 32'(dctl_r[dsel]);
						dpc_pkg::DW_NEXT: rdata_r <= 32'(dnext_r[dsel]);
					endcase
				end
			end
		end
	end

	// ****************************************************************
	// Channel context
	// ****************************************************************
	// Each channel keeps its own pointers, so a preempted channel picks
	// up exactly where it left off.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			act_r <= '0;
			for (int c = 0; c < NC; c++)
			begin
				cdesc_r[c] <= '0;
				ccnt_r[c] <= '0;
				csrc_r[c] <= '0;
				cdst_r[c] <= '0;
			end
		end
		else if (ce)
		begin
			for (int c = 0; c < NC; c++)
			begin
				if (cancel[c])
					act_r[c] <= 1'b0;
				else if (ld[c])
				begin
					act_r[c] <= 1'b1;
					cdesc_r[c] <= li[c];
					ccnt_r[c] <= dctl_r[li[c]][15:0];
					csrc_r[c] <= dsrc_r[li[c]];
					cdst_r[c] <= ddst_r[li[c]];
				end
				else if (adv[c])
				begin
					if (eng_end)
						act_r[c] <= 1'b0;
					else
					begin
						if (!eng_ctl[dpc_pkg::CTL_UNB_BIT])
							ccnt_r[c] <= ccnt_r[c] - 16'h1;
						if (eng_ctl[dpc_pkg::CTL_SINC_BIT])
							csrc_r[c] <= csrc_r[c] + 16'h1;
						if (eng_ctl[dpc_pkg::CTL_DINC_BIT])
							cdst_r[c] <= cdst_r[c] + 16'h1;
					end
				end
			end
		end
	end

	// ****************************************************************
	// Bus engine
	// ****************************************************************
	// One byte is read then written per grant. Arbitration happens only
	// in idle, so a preempting channel waits for the byte in flight.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			state_r <= dpc_pkg::ST_IDLE;
			eng_ch_r <= '0;
			wait_r <= '0;
			bus_req_r <= 1'b0;
			bus_we_r <= 1'b0;
			bus_addr_r <= '0;
			bus_wdata_r <= '0;
		end
		else if (ce)
		begin
			unique case (state_r)
				dpc_pkg::ST_IDLE:
				begin
					if (ab.take)
					begin
						eng_ch_r <= ab.gnt_ch;
						bus_addr_r <= csrc_r[ab.gnt_ch];
						bus_we_r <= 1'b0;
						wait_r <= '0;
						state_r <= dpc_pkg::ST_READ;
					end
				end
				dpc_pkg::ST_READ, dpc_pkg::ST_WRITE:
				begin
					if (!bus_req_r)
					begin
						if (!cpu_req || wait_r == dpc_pkg::CPU_WAIT_MAX)
							bus_req_r <= 1'b1;
						else
							wait_r <= wait_r + 4'h1;
					end
					else if (bus_ack)
					begin
						bus_req_r <= 1'b0;
						wait_r <= '0;
						if (state_r == dpc_pkg::ST_READ)
						begin
							bus_we_r <= 1'b1;
							bus_addr_r <= cdst_r[eng_ch_r];
							bus_wdata_r <= bus_rdata;
							state_r <= dpc_pkg::ST_WRITE;
						end
						else
						begin
							bus_we_r <= 1'b0;
							state_r <= dpc_pkg::ST_IDLE;
						end
					end
				end
			endcase
		end
	end

	// ****************************************************************
	// Events and channel chaining
	// ****************************************************************
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			evt_done_r <= '0;
			evt_end_r <= '0;
			chain_go_r <= 1'b0;
			chain_tgt_r <= '0;
		end
		else if (ce)
		begin
			evt_done_r <= '0;
			evt_end_r <= '0;
			chain_go_r <= 1'b0;
			if (adv[eng_ch_r] && eng_end)
			begin
				evt_done_r[eng_ch_r] <= eng_ctl[dpc_pkg::CTL_EVT_BIT];
				evt_end_r[eng_ch_r] <= eng_ctl[dpc_pkg::CTL_LAST_BIT];
				chain_go_r <= eng_ctl[dpc_pkg::CTL_LAST_BIT]
					&& cfg_r[eng_ch_r][dpc_pkg::CFG_CHEN_BIT];
				chain_tgt_r <= cfg_r[eng_ch_r][dpc_pkg::CFG_CHTGT_LSB +: 5];
			end
		end
	end

endmodule

`default_nettype wire

// >>> sim/dpc_bus_mem.sv
`default_nettype none

// ********************************
// Byte memory behind the system bus
// ********************************
module dpc_bus_mem
(
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// Engine side of the bus.
	input  wire logic        bus_req,
	input  wire logic        bus_we,
	input  wire logic [15:0] bus_addr,
	input  wire logic [7:0]  bus_wdata,
	output logic      [7:0]  bus_rdata,
	output logic             bus_ack,
	// Answer delay in cycles.
	input  wire logic [3:0]  wait_n
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [7:0] mem [65536];
	logic [3:0] cnt_r;

	initial
	begin
		for (int i = 0; i < 65536; i++)
			mem[i] = 8'(i) ^ 8'(i >> 8);
	end

	// Outside the acknowledged read the data lines show a wrong value.
	assign bus_rdata = (bus_ack && !bus_we) ? mem[bus_addr] : ~mem[bus_addr];

	always @(posedge clk)
	begin
		if (sys_rst || !bus_req || bus_ack)
		begin
			cnt_r <= 4'h0;
			bus_ack <= 1'b0;
		end
		else if (cnt_r == wait_n)
		begin
			bus_ack <= 1'b1;
			if (bus_we)
				mem[bus_addr] <= bus_wdata;
		end
		else
			cnt_r <= cnt_r + 4'h1;
	end
endmodule

`default_nettype wire

// >>> sim/dpc_top_chk.sv
`default_nettype none

// ********************************
// Port checks of the engine
// ********************************
module dpc_top_chk
(
	// Clock and reset.
	input wire logic                       clk,
	input wire logic                       sys_rst,
	// Watched ports.
	input wire logic                       reg_rd,
	input wire logic [31:0]                reg_rdata,
	input wire logic                       cpu_req,
	input wire logic                       bus_req,
	input wire logic                       bus_we,
	input wire logic [dpc_pkg::BADDR_W-1:0] bus_addr,
	input wire logic [7:0]                 bus_wdata,
	input wire logic                       bus_ack,
	input wire logic [dpc_pkg::NUM_CH-1:0] ch_evt_done,
	input wire logic [dpc_pkg::NUM_CH-1:0] ch_evt_end
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [4:0] cpu_cnt_r;

	// Saturates so that a long CPU burst never wraps back to a small count.
	always_ff @(posedge clk)
	begin
		if (sys_rst || !cpu_req)
			cpu_cnt_r <= 5'h00;
		else if (cpu_cnt_r != 5'h1F)
			cpu_cnt_r <= cpu_cnt_r + 5'h01;
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	property p_rd_zero;
		!$past(reg_rd) |-> reg_rdata == 32'h0;
	endproperty
	a_rd_zero: assert property (p_rd_zero)
		else $error("read data seen outside its cycle");

	property p_req_hold;
		bus_req && !bus_ack |=> bus_req && $stable(bus_addr)
			&& $stable(bus_we) && $stable(bus_wdata);
	endproperty
	a_req_hold: assert property (p_req_hold)
		else $error("bus access changed before its answer");

	property p_req_drop;
		bus_req && bus_ack |=> !bus_req;
	endproperty
	a_req_drop: assert property (p_req_drop)
		else $error("bus request kept after answer");

	property p_wr_phase;
		bus_req && bus_ack && !bus_we |=> !bus_req ##[0:17] (bus_req && bus_we);
	endproperty
	a_wr_phase: assert property (p_wr_phase)
		else $error("read not followed by its write");

	property p_cpu_first;
		$rose(bus_req) && $past(cpu_req) |-> cpu_cnt_r >= 5'h0E;
	endproperty
	a_cpu_first: assert property (p_cpu_first)
		else $error("bus taken from the CPU too early");

	property p_evt_pulse;
		ch_evt_done != '0 |=> (ch_evt_done & $past(ch_evt_done)) == '0;
	endproperty
	a_evt_pulse: assert property (p_evt_pulse)
		else $error("done event longer than one cycle");

	property p_evt_one;
		$onehot0(ch_evt_done | ch_evt_end);
	endproperty
	a_evt_one: assert property (p_evt_one)
		else $error("events of two channels at once");

	property p_evt_cause;
		(ch_evt_done | ch_evt_end) != '0 |-> $past(bus_ack) && $past(bus_we);
	endproperty
	a_evt_cause: assert property (p_evt_cause)
		else $error("event without a finished write");
endmodule

bind dpc_top dpc_top_chk u_chk (.clk, .sys_rst, .reg_rd, .reg_rdata,
	.cpu_req, .bus_req, .bus_we, .bus_addr, .bus_wdata, .bus_ack,
	.ch_evt_done, .ch_evt_end);

`default_nettype wire

// >>> sim/dpc_top_test.sv
`default_nettype none

module dpc_top_test;
	timeunit 1ns;
	timeprecision 1ns;

	logic                        clk;
	logic                        sys_rst;
	logic                        ce;
	logic [dpc_pkg::RADDR_W-1:0] reg_addr;
	logic [31:0]                 reg_wdata;
	logic                        reg_wr;
	logic                        reg_rd;
	logic [31:0]                 reg_rdata;
	logic [dpc_pkg::NUM_CH-1:0]  trig_in;
	logic                        cpu_req;
	logic                        bus_req;
	logic                        bus_we;
	logic [15:0]                 bus_addr;
	logic [7:0]                  bus_wdata;
	logic [7:0]                  bus_rdata;
	logic                        bus_ack;
	logic [dpc_pkg::NUM_CH-1:0]  evt_done;
	logic [dpc_pkg::NUM_CH-1:0]  evt_end;
	logic [3:0]                  wait_n;
	int                          err_total;
	int                          checks_done;

	dpc_top u_dut (.clk(clk), .sys_rst(sys_rst), .ce(ce),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .trig_in(trig_in),
		.cpu_req(cpu_req), .bus_req(bus_req), .bus_we(bus_we),
		.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
		.bus_ack(bus_ack), .ch_evt_done(evt_done), .ch_evt_end(evt_end));

	dpc_bus_mem u_mem (.clk(clk), .sys_rst(sys_rst), .bus_req(bus_req),
		.bus_we(bus_we), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_rdata(bus_rdata), .bus_ack(bus_ack), .wait_n(wait_n));

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ********************************
	// Helpers
	// ********************************
	function automatic logic [7:0] pat(input logic [15:0] a);
		return a[7:0] ^ a[15:8];
	endfunction

	function automatic logic [31:0] ctl(input logic [15:0] n,
		input logic ev, input logic la);
		return {11'h0, la, ev, 2'b11, 1'b0, n};
	endfunction

	function automatic logic [31:0] cfg(input logic [2:0] p, input logic nr,
		input logic [6:0] f, input logic cn, input logic [4:0] t);
		return {13'h0, t, cn, f, 2'b01, nr, p};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] v;
		rd(a, v);
		chk(v, e);
	endtask

	task automatic td(input int d, input logic [15:0] s, input logic [15:0] t,
		input logic [31:0] c, input int n);
		logic [11:0] b;
		b = dpc_pkg::REG_DESC_BASE + 12'(4 * d);
		wr(b, {16'h0, s});
		wr(b + 12'h1, {16'h0, t});
		wr(b + 12'h2, c);
		wr(b + 12'h3, 32'(n));
	endtask

	// Counts one channel's event pulses under a bound.
	task automatic wevt(input int ch, input int n, input logic e);
		int k;
		k = 0;
		for (int i = 0; i < 3000 && k < n; i++)
		begin
			@(posedge clk);
			#1 k += (e ? evt_end[ch] : evt_done[ch]) === 1'b1;
		end
		chk(32'(k), 32'(n));
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ********************************
	// Scenarios
	// ********************************
	task automatic t_regs;
		rdc(dpc_pkg::REG_CTRL, 32'h0);
		wr(12'h057, 32'h7FFDF);
		rdc(12'h057, 32'h7FFDF);
		wr(12'h057, 32'h0);
		ce <= 1'b0;
		wr(12'h057, 32'h1);
		ce <= 1'b1;
		rdc(12'h057, 32'h0);
		wr(12'h3FE, 32'h1ABCD);
		rdc(12'h3FE, 32'h1ABCD);
		wr(12'h060, 32'hFFFFFFFF);
		rdc(12'h060, 32'h0);
		rdc(12'h100, 32'h0);
		$display("test regs done");
	endtask

	task automatic t_simple(input logic pin, input logic cpu,
		input logic [3:0] w, input logic [15:0] o);
		wait_n <= w;
		cpu_req <= cpu;
		td(0, 16'h1000, 16'h8000 + o, ctl(16'h2, 1'b1, 1'b1), 0);
		td(1, 16'h1010, 16'h8010 + o, ctl(16'h0, 1'b0, 1'b1), 1);
		wr(dpc_pkg::REG_CFG_BASE + 12'h17, cfg(3'h4, 1'b0, 7'h1, 1'b0, 5'h0));
		wr(dpc_pkg::REG_CFG_BASE, cfg(3'h5, 1'b0, 7'h0, 1'b1, 5'h17));
		wr(dpc_pkg::REG_CTRL, 32'h1);
		if (pin)
		begin
			trig_in[0] <= 1'b1;
			repeat (4) @(posedge clk);
			trig_in[0] <= 1'b0;
		end
		else
			wr(dpc_pkg::REG_TRIG, 32'h0);
		wevt(0, 1, 1'b1);
		wevt(23, 1, 1'b1);
		for (int k = 0; k < 3; k++)
			chk(32'(u_mem.mem[16'h8000 + o + 16'(k)]), 32'(pat(16'h1000 + 16'(k))));
		chk(32'(u_mem.mem[16'h8010 + o]), 32'(pat(16'h1010)));
		cpu_req <= 1'b0;
		wait_n <= 4'h0;
		$display("test simple done");
	endtask

	task automatic t_ring(input int ch, input int f, input int n);
		logic [31:0] v;
		logic [15:0] s;
		s = 16'h3000 + 16'(16 * ch);
		for (int k = 0; k < n; k++)
			td(f + k, s + 16'(k), s + 16'h6000 + 16'(k),
				ctl(16'h0, 1'b1, 1'b0), f + (k + 1) % n);
		wr(dpc_pkg::REG_CFG_BASE + 12'(ch), cfg(3'h2, 1'b0, 7'(f), 1'b0, 5'h0));
		wr(dpc_pkg::REG_TRIG, 32'(ch));
		wevt(ch, n, 1'b0);
		wr(dpc_pkg::REG_DESC_BASE + 12'(4 * f + 1), {16'h0, s + 16'h7000});
		wevt(ch, 2 * n, 1'b0);
		wr(dpc_pkg::REG_CFG_BASE + 12'(ch), 32'h20 | cfg(3'h2, 1'b0,
			7'(f), 1'b0, 5'h0));
		repeat (10) @(posedge clk);
		v = 32'h0;
		repeat (40)
		begin
			@(posedge clk);
			#1 v += 32'(evt_done[ch]);
		end
		chk(v, 32'h0);
		wr(dpc_pkg::REG_CANCEL, 32'(ch));
		repeat (20) @(posedge clk);
		rd(dpc_pkg::REG_CHST_BASE + 12'(ch), v);
		chk(32'(v[23]), 32'h0);
		for (int k = 0; k < n; k++)
			chk(32'(u_mem.mem[s + 16'h6000 + 16'(k)]), 32'(pat(s + 16'(k))));
		chk(32'(u_mem.mem[s + 16'h7000]), 32'(pat(s)));
		$display("test ring done");
	endtask

	// The loser's first destination byte tells whether it moved yet.
	task automatic t_race(input int x, input int y, input logic [2:0] px,
		input logic [2:0] py, input logic nx, input logic [31:0] ct,
		input logic xw, input int m);
		logic [31:0] v;
		int l;
		td(40 + x, 16'h1000, 16'h8000 + 16'(16 * x), ctl(16'h7, 1'b0, 1'b1), 0);
		td(40 + y, 16'h1000, 16'h8000 + 16'(16 * y), ctl(16'h7, 1'b0, 1'b1), 0);
		wr(dpc_pkg::REG_CTRL, ct);
		wr(dpc_pkg::REG_CFG_BASE + 12'(x), cfg(px, nx, 7'(40 + x), 1'b0, 5'h0));
		wr(dpc_pkg::REG_CFG_BASE + 12'(y), cfg(py, 1'b0, 7'(40 + y), 1'b0, 5'h0));
		wr(dpc_pkg::REG_TRIG, 32'(x));
		wr(dpc_pkg::REG_TRIG, 32'(y));
		l = xw ? y : x;
		wevt(xw ? x : y, 1, 1'b1);
		rd(dpc_pkg::REG_CHST_BASE + 12'(l), v);
		chk(32'(v[23]), 32'h1);
		if (m == 1)
			chk(32'(u_mem.mem[16'h8000 + 16'(16 * l)]), 32'(pat(16'h8000 + 16'(16 * l))));
		if (m == 2)
			chk(32'(u_mem.mem[16'h8000 + 16'(16 * l)]), 32'(pat(16'h1000)));
		wevt(l, 1, 1'b1);
		$display("test race done");
	endtask

	task automatic t_unb;
		td(70, 16'h5000, 16'h5800, ctl(16'h0, 1'b0, 1'b1) | 32'h10000, 0);
		wr(dpc_pkg::REG_CFG_BASE + 12'h5, cfg(3'h4, 1'b0, 7'h46, 1'b0, 5'h0));
		wr(dpc_pkg::REG_TRIG, 32'h5);
		repeat (200) @(posedge clk);
		wr(dpc_pkg::REG_CANCEL, 32'h5);
		chk(32'(u_mem.mem[16'h5805]), 32'(pat(16'h5005)));
		$display("test unbounded done");
	endtask

	initial
	begin
		err_total = 0;
		checks_done = 0;
		sys_rst = 1'b1;
		ce = 1'b1;
		reg_addr = '0;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		trig_in = '0;
		cpu_req = 1'b0;
		wait_n = 4'h0;
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		t_regs;
		t_simple(1'b0, 1'b0, 4'h0, 16'h0000);
		t_simple(1'b1, 1'b1, 4'h3, 16'h0800);
		t_ring(2, 10, 1);
		t_ring(3, 20, 2);
		t_ring(4, 30, 3);
		t_race(11, 12, 3'h7, 3'h0, 1'b0, 32'h1, 1'b0, 0);
		t_race(13, 14, 3'h3, 3'h3, 1'b1, 32'h3, 1'b1, 1);
		t_race(15, 16, 3'h3, 3'h3, 1'b0, 32'h3, 1'b1, 2);
		t_race(17, 18, 3'h2, 3'h3, 1'b0, 32'h3, 1'b1, 2);
		t_race(19, 20, 3'h2, 3'h3, 1'b0, 32'h1, 1'b1, 1);
		t_race(21, 22, 3'h1, 3'h2, 1'b0, 32'h3, 1'b1, 1);
		t_unb;
		results;
	end

	// The tests need a few thousand cycles; this bound leaves ample margin.
	initial
	begin
		repeat (20000) @(posedge clk);
		err_total++;
		results;
	end
endmodule

`default_nettype wire
